// File: core/mfpwm_pkg.sv
// Behaviour
// RULE_01 - pad select: four 8-bit pad fields
// RULE_02 - software writes reserved fields with reset values
// RULE_03 - two 16-bit counters, two reload registers
// RULE_04 - 8-bit programmable prescaler on system clock
// RULE_05 - per-counter clock select; no-clock stops it
// RULE_06 - five modes with fixed counter roles; only mode 1 is implemented here
// RULE_07 - counter one reloads alternately A then B
// RULE_08 - output toggles on every counter one underflow
// RULE_09 - software picks initial output level
// RULE_10 - every restart takes first reload from A
// RULE_11 - mode select field picks mode 1
// RULE_12 - pending flags A/B on reloads, enabled interrupts
// RULE_13 - mode 1 counter two is timer, underflow interrupt
// RULE_14 - pulse train: mode 1 plus train enable
// RULE_15 - train: underflow toggles and decrements counter two
// RULE_16 - train: counter two underflow stops counter one
// RULE_17 - train: counter two underflow presets zero, no reload
// RULE_18 - software reloads counter two before next train
// RULE_19 - train length is counter two plus one
// RULE_20 - hardware start on selectable input B edge
// RULE_21 - software start via software trigger bit
// RULE_22 - software trigger only after unit enable
// RULE_23 - disabled after reset; train starts reload A
// RULE_24 - underflow: decrement at zero, actions same edge
package mfpwm_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CNT1   = 8'h00;
  localparam logic [7:0] ADR_CNT2   = 8'h04;
  localparam logic [7:0] ADR_CRA    = 8'h08;
  localparam logic [7:0] ADR_CRB    = 8'h0C;
  localparam logic [7:0] ADR_MCTRL  = 8'h10;
  localparam logic [7:0] ADR_CKSEL  = 8'h14;
  localparam logic [7:0] ADR_PRESC  = 8'h18;
  localparam logic [7:0] ADR_IRQ    = 8'h1C;
  localparam logic [7:0] ADR_TRIG   = 8'h20;
  localparam logic [7:0] ADR_PADSEL = 8'h44;

  // ----------------------------------------------------------------
  // field positions, codes and reset values
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_EN_A  = 0;
  localparam int unsigned IRQ_EN_B  = 1;
  localparam int unsigned IRQ_EN_D  = 2;
  localparam int unsigned IRQ_PND_A = 4;
  localparam int unsigned IRQ_PND_B = 5;
  localparam int unsigned IRQ_PND_D = 6;
  localparam int unsigned TRIG_BIT  = 0;
  localparam logic [2:0]  MODE_PWM  = 3'h1;
  localparam logic [7:0]  PAD_MAX   = 8'h0E;
  localparam logic [15:0] CNT_ZERO  = 16'h0000;
  localparam logic [15:0] CNT_FULL  = 16'hFFFF;
  localparam logic [31:0] REG_RST   = 32'h00000000;

  typedef enum logic [1:0] {
    CK_NONE  = 2'b00,
    CK_PRESC = 2'b01,
    CK_EVENT = 2'b10,
    CK_ACCUM = 2'b11
  } mfpwm_ck_e;

  typedef enum logic [1:0] {
    PT_IDLE = 2'b00,
    PT_RUN  = 2'b01
  } mfpwm_pt_e;

  typedef struct packed {
    logic [22:0] rsvd;
    logic        pin_a_en;
    logic        pin_b_rise;
    logic        software_start_enable;
    logic        pulse_train_enable;
    logic        unit_enable;
    logic        output_initial_level;
    logic [2:0]  mode_select_field;
  } mfpwm_mctrl_s;

  typedef struct packed {
    logic [27:0] rsvd;
    mfpwm_ck_e   ck2;
    mfpwm_ck_e   ck1;
  } mfpwm_cksel_s;

  typedef struct packed {
    logic [7:0] unit2_input_b_pad;
    logic [7:0] unit2_input_a_pad;
    logic [7:0] unit1_input_b_pad;
    logic [7:0] unit1_input_a_pad;
  } mfpwm_padsel_s;

endpackage

// File: core/mfpwm_timer.sv
`timescale 1ns/1ps
`default_nettype none
module mfpwm_timer
  import mfpwm_pkg::*;
#(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned PSC_W = 8,
  parameter int unsigned NPADS = 15
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // avalon-mm slave
  input  wire logic [7:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output var  logic [31:0]      avs_readdata,
  output var  logic             avs_waitrequest,
  // pads
  input  wire logic             timer_pin_b,
  input  wire logic [NPADS-1:0] pads_in,
  output var  logic             pwm_output_pad,
  output var  logic [3:0]       pad_level,
  // interrupts
  output var  logic             irq_a,
  output var  logic             irq_b,
  output var  logic             irq_d
);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [CNT_W-1:0] counter_one_r;      // [RULE_03]
  logic [CNT_W-1:0] counter_two_r;      // [RULE_03]
  logic [CNT_W-1:0] reload_capture_a_r; // [RULE_03]
  logic [CNT_W-1:0] reload_capture_b_r; // [RULE_03]
  mfpwm_mctrl_s     mode_control_reg_r;
  mfpwm_cksel_s     clock_selector_reg_r;
  mfpwm_padsel_s    timer_input_pad_select_r;
  logic [PSC_W-1:0] presc_r;
  logic [PSC_W-1:0] div_cnt_r;
  logic [2:0]       irq_en_r;
  logic             pending_flag_a_r;
  logic             pending_flag_b_r;
  logic             pending_flag_d_r;
  logic             software_trigger_r;
  logic             next_b_r;
  logic             pwm_r;
  logic             pin_b_q_r;
  mfpwm_pt_e        pt_state_r;
  logic             wait_r;
  logic [31:0]      rdata_r;
  logic [3:0]       pad_level_r;
  logic             irq_a_r;
  logic             irq_b_r;
  logic             irq_d_r;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  logic wr_en;
  logic rd_take;
  logic wr_cnt1;
  logic wr_cnt2;
  logic wr_irq;

  // a write lands at the edge where waitrequest is seen low
  assign wr_en   = avs_write && !wait_r;
  assign rd_take = avs_read && wait_r;
  assign wr_cnt1 = wr_en && (avs_address == ADR_CNT1);
  assign wr_cnt2 = wr_en && (avs_address == ADR_CNT2);
  assign wr_irq  = wr_en && (avs_address == ADR_IRQ);

  // byte-enable merge shared by every writable register except the trigger bit and the write-one-to-clear pending flags
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ------------------------------------------------------------------
  // clock sources
  // ------------------------------------------------------------------
  logic      presc_tick;
  logic      evt_edge;
  logic      mode_one;
  logic      pt_mode;
  logic      run1;
  logic      tick1;
  logic      tick2;
  logic      uf1;
  logic      uf2;
  logic      pt_start;

  // prescaler divides by presc_r + 1; the tick is one cycle wide [RULE_04]
  assign presc_tick = (div_cnt_r == presc_r);

  // input b edge, polarity from the control register [RULE_20]
  assign evt_edge = mode_control_reg_r.pin_b_rise ? (timer_pin_b && !pin_b_q_r)
                                                  : (!timer_pin_b && pin_b_q_r);

  // one tick per selected source; no-clock never ticks [RULE_05]
  function automatic logic src_tick(input mfpwm_ck_e ck, input logic psc,
                                    input logic edg, input logic lvl);
    logic t;
    t = 1'b0;
    case (ck)
      CK_PRESC: t = psc;
      CK_EVENT: t = edg;
      CK_ACCUM: t = psc && lvl;
      default:  t = 1'b0;
    endcase
    return t;
  endfunction

  // mode decode; only mode 1 and its pulse-train variant run here [RULE_06] [RULE_11] [RULE_14]
  assign mode_one = mode_control_reg_r.unit_enable &&
                    (mode_control_reg_r.mode_select_field == MODE_PWM);
  assign pt_mode  = mode_one && mode_control_reg_r.pulse_train_enable;

  // counter one runs only with a clock and, in a train, only while armed [RULE_16]
  assign run1  = mode_one && (clock_selector_reg_r.ck1 != CK_NONE) &&
                 (!pt_mode || (pt_state_r == PT_RUN));
  assign tick1 = run1 && src_tick(clock_selector_reg_r.ck1, presc_tick, evt_edge, timer_pin_b);
  // underflow is a decrement taken while the counter holds zero [RULE_24]
  assign uf1   = tick1 && (counter_one_r == CNT_ZERO);

  // counter two: own clock in mode 1, counter one underflows in a train [RULE_13] [RULE_15]
  assign tick2 = pt_mode ? uf1
                         : (mode_one &&
                            src_tick(clock_selector_reg_r.ck2, presc_tick, evt_edge, timer_pin_b));
  assign uf2   = tick2 && (counter_two_r == CNT_ZERO);

  // start request: software bit or hardware edge on input b [RULE_20] [RULE_21]
  assign pt_start = pt_mode && (mode_control_reg_r.software_start_enable ? software_trigger_r
                                                                         : evt_edge);

  // ------------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------------
  // one wait cycle per access; read data is registered on the same edge where waitrequest drops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !((avs_read || avs_write) && wait_r);
    end
  end

  // read mux; unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_r <= REG_RST;
    end else if (rd_take) begin
      case (avs_address)
        ADR_CNT1:   rdata_r <= 32'(counter_one_r);
        ADR_CNT2:   rdata_r <= 32'(counter_two_r);
        ADR_CRA:    rdata_r <= 32'(reload_capture_a_r);
        ADR_CRB:    rdata_r <= 32'(reload_capture_b_r);
        ADR_MCTRL:  rdata_r <= mode_control_reg_r;
        ADR_CKSEL:  rdata_r <= clock_selector_reg_r;
        ADR_PRESC:  rdata_r <= 32'(presc_r);
        ADR_IRQ:    rdata_r <= REG_RST | (32'(irq_en_r) << IRQ_EN_A) |
                               (32'(pending_flag_a_r) << IRQ_PND_A) |
                               (32'(pending_flag_b_r) << IRQ_PND_B) |
                               (32'(pending_flag_d_r) << IRQ_PND_D);
        ADR_TRIG:   rdata_r <= 32'(software_trigger_r) << TRIG_BIT;
        ADR_PADSEL: rdata_r <= timer_input_pad_select_r;
        default:    rdata_r <= REG_RST;
      endcase
    end
  end

  // configuration registers; reserved bits of the mode and clock select registers are kept as written [RULE_02]
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_control_reg_r       <= mfpwm_mctrl_s'(REG_RST); // disabled after reset [RULE_23]
      clock_selector_reg_r     <= mfpwm_cksel_s'(REG_RST);
      timer_input_pad_select_r <= mfpwm_padsel_s'(REG_RST);
      reload_capture_a_r       <= CNT_ZERO;
      reload_capture_b_r       <= CNT_ZERO;
      presc_r                  <= PSC_W'(REG_RST);
      irq_en_r                 <= 3'(REG_RST);
    end else if (wr_en) begin
      case (avs_address)
        ADR_MCTRL:  mode_control_reg_r <= mfpwm_mctrl_s'(be_merge(mode_control_reg_r,
                                            avs_writedata, avs_byteenable));
        ADR_CKSEL:  clock_selector_reg_r <= mfpwm_cksel_s'(be_merge(clock_selector_reg_r,
                                              avs_writedata, avs_byteenable));
        ADR_PADSEL: timer_input_pad_select_r <= mfpwm_padsel_s'(be_merge(
                      timer_input_pad_select_r, avs_writedata, avs_byteenable)); // [RULE_01]
        ADR_CRA:    reload_capture_a_r <= CNT_W'(be_merge(32'(reload_capture_a_r),
                                            avs_writedata, avs_byteenable));
        ADR_CRB:    reload_capture_b_r <= CNT_W'(be_merge(32'(reload_capture_b_r),
                                            avs_writedata, avs_byteenable));
        ADR_PRESC:  presc_r <= PSC_W'(be_merge(32'(presc_r), avs_writedata, avs_byteenable));
        ADR_IRQ:    irq_en_r <= 3'(be_merge(32'(irq_en_r), avs_writedata, avs_byteenable));
        default:    irq_en_r <= irq_en_r;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // prescaler and input edge history
  // ------------------------------------------------------------------
  // free-running divider, restarts on every tick [RULE_04]
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_cnt_r <= PSC_W'(REG_RST);
    end else if (presc_tick) begin
      div_cnt_r <= PSC_W'(REG_RST);
    end else begin
      div_cnt_r <= div_cnt_r + PSC_W'(1);
    end
  end

  // previous level of input b for edge detection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_b_q_r <= 1'b0;
    end else begin
      pin_b_q_r <= timer_pin_b;
    end
  end

  // ------------------------------------------------------------------
  // counter one, reload alternation and output
  // ------------------------------------------------------------------
  // a software write wins over a count in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      counter_one_r <= CNT_ZERO;
    end else if (wr_cnt1) begin
      counter_one_r <= CNT_W'(be_merge(32'(counter_one_r), avs_writedata, avs_byteenable));
    end else if (uf1) begin
      counter_one_r <= next_b_r ? reload_capture_b_r : reload_capture_a_r; // [RULE_07]
    end else if (tick1) begin
      counter_one_r <= counter_one_r - CNT_W'(1);
    end
  end

  // alternation pointer; any stop returns it to A [RULE_10] [RULE_23]
  always_ff @(posedge sys_clk) begin
    if (rst || !run1) begin
      next_b_r <= 1'b0;
    end else if (uf1) begin
      next_b_r <= !next_b_r; // [RULE_07]
    end
  end

  // output parks at the initial level while stopped, toggles per underflow [RULE_08] [RULE_09]
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwm_r <= 1'b0;
    end else if (!run1) begin
      pwm_r <= mode_control_reg_r.output_initial_level; // [RULE_09]
    end else if (uf1 && mode_control_reg_r.pin_a_en) begin
      pwm_r <= !pwm_r; // [RULE_08] [RULE_15]
    end
  end

  // ------------------------------------------------------------------
  // counter two
  // ------------------------------------------------------------------
  // mode 1 wraps to all ones; a train presets zero and never reloads [RULE_17]
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      counter_two_r <= CNT_ZERO;
    end else if (wr_cnt2) begin
      counter_two_r <= CNT_W'(be_merge(32'(counter_two_r), avs_writedata, avs_byteenable));
    end else if (uf2) begin
      counter_two_r <= pt_mode ? CNT_ZERO : CNT_FULL; // [RULE_17] [RULE_13]
    end else if (tick2) begin
      counter_two_r <= counter_two_r - CNT_W'(1); // [RULE_15]
    end
  end

  // ------------------------------------------------------------------
  // pulse-train sequencer
  // ------------------------------------------------------------------
  // the underflow of counter two coincides with the end of a phase, so
  // counter one stops on that same edge: count + 1 phases per train [RULE_16] [RULE_19]
  always_ff @(posedge sys_clk) begin
    if (rst || !pt_mode) begin
      pt_state_r <= PT_IDLE;
    end else begin
      case (pt_state_r)
        PT_IDLE: begin
          if (pt_start) begin
            pt_state_r <= PT_RUN; // [RULE_20] [RULE_21]
          end
        end
        PT_RUN: begin
          if (uf2) begin
            pt_state_r <= PT_IDLE; // [RULE_16]
          end
        end
        default: pt_state_r <= PT_IDLE;
      endcase
    end
  end

  // software trigger: set by software, cleared by hardware when the train ends
  // software must enable the unit first; a trigger set while disabled waits
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      software_trigger_r <= 1'b0;
    end else if (wr_en && (avs_address == ADR_TRIG) && avs_byteenable[0] &&
                 avs_writedata[TRIG_BIT]) begin
      software_trigger_r <= 1'b1; // [RULE_21]
    end else if (pt_mode && (pt_state_r == PT_RUN) && uf2) begin
      software_trigger_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // pending flags and interrupt lines
  // ------------------------------------------------------------------
  // write one to clear; a reload in the clearing cycle still sets [RULE_12]
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pending_flag_a_r <= 1'b0;
      pending_flag_b_r <= 1'b0;
      pending_flag_d_r <= 1'b0;
    end else begin
      pending_flag_a_r <= (uf1 && !next_b_r) ||
        (pending_flag_a_r && !(wr_irq && avs_byteenable[0] && avs_writedata[IRQ_PND_A]));
      pending_flag_b_r <= (uf1 && next_b_r) ||
        (pending_flag_b_r && !(wr_irq && avs_byteenable[0] && avs_writedata[IRQ_PND_B]));
      pending_flag_d_r <= uf2 ||
        (pending_flag_d_r && !(wr_irq && avs_byteenable[0] && avs_writedata[IRQ_PND_D]));
    end
  end

  // registered interrupt lines, one per source [RULE_12] [RULE_13]
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_a_r <= 1'b0;
      irq_b_r <= 1'b0;
      irq_d_r <= 1'b0;
    end else begin
      irq_a_r <= pending_flag_a_r && irq_en_r[IRQ_EN_A];
      irq_b_r <= pending_flag_b_r && irq_en_r[IRQ_EN_B];
      irq_d_r <= pending_flag_d_r && irq_en_r[IRQ_EN_D];
    end
  end

  // ------------------------------------------------------------------
  // pad selection for the capture inputs
  // ------------------------------------------------------------------
  // codes past the last pad select nothing and read low [RULE_01]
  for (genvar g = 0; g < 4; g++) begin : g_pad
    logic [7:0] code;
    assign code = timer_input_pad_select_r[g*8 +: 8];
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        pad_level_r[g] <= 1'b0;
      end else begin
        pad_level_r[g] <= (code <= PAD_MAX) ? pads_in[code[3:0]] : 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign pwm_output_pad  = pwm_r;
  assign pad_level       = pad_level_r;
  assign irq_a           = irq_a_r;
  assign irq_b           = irq_b_r;
  assign irq_d           = irq_d_r;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_uf_on_a;
    uf1 && !next_b_r && !wr_cnt1;
  endsequence

  sequence s_uf_on_b;
    uf1 && next_b_r && !wr_cnt1;
  endsequence

  property p_reload_a;
    s_uf_on_a |=> (counter_one_r == $past(reload_capture_a_r)) && next_b_r;
  endproperty
  a_reload_a: assert property (p_reload_a) else $error("reload from A missing"); // [RULE_07]

  property p_reload_b;
    s_uf_on_b |=> (counter_one_r == $past(reload_capture_b_r)) && !next_b_r;
  endproperty
  a_reload_b: assert property (p_reload_b) else $error("reload from B missing"); // [RULE_07]

  property p_toggle;
    (uf1 && mode_control_reg_r.pin_a_en) |=> (pwm_r != $past(pwm_r));
  endproperty
  a_toggle: assert property (p_toggle) else $error("output did not toggle"); // [RULE_08]

  property p_pend_a;
    s_uf_on_a |=> pending_flag_a_r ##1 (irq_a_r == irq_en_r[IRQ_EN_A]);
  endproperty
  a_pend_a: assert property (p_pend_a) else $error("pending A or irq A wrong"); // [RULE_12]

  property p_restart_a;
    !run1 |=> !next_b_r;
  endproperty
  a_restart_a: assert property (p_restart_a) else $error("restart not from A"); // [RULE_10]

  property p_pt_stop;
    (pt_mode && uf2 && !wr_cnt2) |=> (counter_two_r == CNT_ZERO) && (pt_state_r == PT_IDLE);
  endproperty
  a_pt_stop: assert property (p_pt_stop) else $error("train did not stop at zero"); // [RULE_17]

  property p_pt_dec;
    (pt_mode && uf1 && (counter_two_r != CNT_ZERO) && !wr_cnt2)
      |=> (counter_two_r == $past(counter_two_r) - CNT_W'(1));
  endproperty
  a_pt_dec: assert property (p_pt_dec) else $error("train count not decremented"); // [RULE_15]

  property p_noclk;
    (clock_selector_reg_r.ck1 == CK_NONE && !wr_cnt1) |=> $stable(counter_one_r);
  endproperty
  a_noclk: assert property (p_noclk) else $error("counter one ran with no clock"); // [RULE_05]

  property p_presc;
    presc_tick |=> (div_cnt_r == PSC_W'(REG_RST));
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler did not restart"); // [RULE_04]

  property p_sw_start;
    (pt_mode && pt_state_r == PT_IDLE && mode_control_reg_r.software_start_enable &&
     software_trigger_r) |=> (pt_state_r == PT_RUN);
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start ignored"); // [RULE_21]

endmodule
`default_nettype wire

// File: verification/mfpwm_pads.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// io pad model: levels on IO0..IO14 and the input B line
// ------------------------------------------------------------
module mfpwm_pads (
  // clock
  input  wire logic        sys_clk,
  // pad levels
  output var  logic [14:0] pads_in,
  output var  logic        timer_pin_b
);
  initial begin
    pads_in     = 15'h0000;
    timer_pin_b = 1'b0;
  end
  // new random pad pattern, changed just after a rising edge
  task automatic shuffle();
    pads_in <= 15'($urandom());
  endtask
  // single rising edge on input B, one full clock wide
  task automatic pulse_b();
    timer_pin_b <= 1'b1;
  endtask
  // line is pulled back low so the edge is never repeated
  always @(posedge sys_clk) begin
    if (timer_pin_b) begin
      timer_pin_b <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verification/mfpwm_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mfpwm_timer_tb;
  import mfpwm_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  logic [7:0]   avs_address = 8'h00;
  logic         avs_read = 1'b0;
  logic         avs_write = 1'b0;
  logic [31:0]  avs_writedata = 32'h0;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  logic [14:0]  pads_in;
  logic         timer_pin_b;
  logic         pwm;
  logic [3:0]   pad_level;
  logic [2:0]   irq;
  logic [31:0]  q;
  logic         lv;
  logic [7:0]   f [4];
  mfpwm_mctrl_s m;
  int           error_cnt = 0;
  int           cmp_count = 0;
  int           cyc = 0;
  int           a, b, n, t;
  int           exp_q [$];

  mfpwm_timer uut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timer_pin_b(timer_pin_b), .pads_in(pads_in), .pwm_output_pad(pwm),
    .pad_level(pad_level), .irq_a(irq[0]), .irq_b(irq[1]), .irq_d(irq[2]));
  mfpwm_pads pads (.sys_clk(sys_clk), .pads_in(pads_in), .timer_pin_b(timer_pin_b));

  always #12.5 sys_clk = ~sys_clk;
  // hang guard: the whole run needs under two thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic wrap_up();
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one avalon access; the idle edge after it keeps strobes from re-rising in one step
  task automatic bus(input logic w, input logic [7:0] adr, input logic [31:0] d);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= adr;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  // cycles until the pwm line next changes
  task automatic wait_tog(output int c);
    c = 0;
    lv = pwm;
    do begin
      @(posedge sys_clk);
      c++;
    end while (pwm === lv);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(90));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    bus(0, ADR_PADSEL, 0); chk("padsel_rst", q, REG_RST);
    bus(0, ADR_MCTRL, 0); chk("mctrl_rst", q, REG_RST);
    bus(0, 8'h30, 0); chk("unmapped", q, 32'h0);
    // codes above the last pad read back but select no pad
    repeat (4) begin
      pads.shuffle();
      foreach (f[i]) f[i] = 8'($urandom_range(15));
      bus(1, ADR_PADSEL, {f[3], f[2], f[1], f[0]});
      bus(0, ADR_PADSEL, 0); chk("padsel", q, {f[3], f[2], f[1], f[0]});
      for (int i = 0; i < 4; i++)
        chk("pad_level", 32'(pad_level[i]), 32'(f[i] <= PAD_MAX ? pads_in[f[i][3:0]] : 1'b0));
    end
    // plain pwm, both start levels, prescaler 0 then 1, second pass after a no-clock stop
    for (int lvl = 0; lvl < 2; lvl++) begin
      a = $urandom_range(9, 2);
      b = $urandom_range(9, 2);
      bus(1, ADR_CRA, a);
      bus(1, ADR_CRB, b);
      bus(1, ADR_PRESC, lvl);
      bus(1, ADR_IRQ, 32'h77);
      m = '0;
      m.mode_select_field = MODE_PWM;
      m.output_initial_level = lvl[0];
      m.unit_enable = 1'b1;
      m.pin_a_en = 1'b1;
      bus(1, ADR_MCTRL, m);
      repeat (2) begin
        exp_q = '{(a + 1) * (lvl + 1), (b + 1) * (lvl + 1)};
        bus(1, ADR_CNT2, 0);
        bus(1, ADR_CNT1, 4);
        // counter two also runs prescaled: it wraps from zero at its first tick
        bus(1, ADR_CKSEL, 5);
        wait_tog(t); chk("pwm_first", pwm, !lvl[0]);
        wait_tog(t); chk("phase_a", t, exp_q.pop_front());
        wait_tog(t); chk("phase_b", t, exp_q.pop_front());
        bus(0, ADR_IRQ, 0); chk("pend_abd", q & 32'h70, 32'h70);
        chk("irq_a", 32'(irq[0]), 32'h1);
        chk("irq_b", 32'(irq[1]), 32'h1);
        chk("irq_d_m1", 32'(irq[2]), 32'h1);
        bus(0, ADR_CNT2, 0); chk("cnt2_wrap", q >> 8, 32'h000000FF);
        bus(1, ADR_IRQ, 32'h77);
        bus(1, ADR_CKSEL, 0);
      end
    end
    // pulse trains: software start, then rising and falling B edges; odd counts end at start level
    for (int hw = 0; hw < 3; hw++) begin
      n = 2 * $urandom_range(2) + 1;
      m.pulse_train_enable = 1'b1;
      m.software_start_enable = (hw == 0);
      m.pin_b_rise = (hw < 2);
      bus(1, ADR_MCTRL, m);
      bus(1, ADR_CNT2, n);
      bus(1, ADR_CNT1, 4);
      bus(1, ADR_CKSEL, 1);
      if (hw > 0) pads.pulse_b();
      else bus(1, ADR_TRIG, 1);
      t = 0;
      repeat (300) begin
        lv = pwm;
        @(posedge sys_clk);
        t += (pwm !== lv);
      end
      chk("pulses", t, n + 1);
      bus(0, ADR_CNT2, 0); chk("cnt2_end", q, 32'(CNT_ZERO));
      bus(0, ADR_TRIG, 0); chk("trig_end", q, 32'h0);
      chk("irq_d", 32'(irq[2]), 32'h1);
      bus(1, ADR_IRQ, 32'h77);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
